// *** rtl/mris_top.sv ***
// Reference source selection, duty command and half-bridge dead-time interlock.
// Assumes speed pin samples are synchronous; analog level arrives digitised.
`timescale 1ns/1ps
`include "mris_cfg.svh"
module mris_top #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [1:0]   source_select,
    input  wire logic         closed_loop_select,
    input  wire logic [W-1:0] analog_level,
    input  wire logic         speed_pin,
    input  wire logic [7:0]   host_speed_cmd,
    input  wire logic [1:0]   speed_range_sel,
    input  wire logic [W-1:0] standby_entry_level,
    input  wire logic [W-1:0] standby_exit_level,
    input  wire logic [W-1:0] analog_full_scale_level,
    input  wire logic [7:0]   standby_entry_duty,
    input  wire logic [7:0]   standby_exit_duty,
    input  wire logic [W-1:0] freq_entry,
    input  wire logic [W-1:0] freq_exit,
    input  wire logic [W-1:0] input_max_freq,
    input  wire logic         bridge_high_req,
    input  wire logic         hs_gate_sensed_on,
    input  wire logic         ls_gate_sensed_on,
    output logic      [7:0]   duty_cmd,
    output logic      [7:0]   speed_ref,
    output logic      [7:0]   current_ref,
    output logic              speed_loop_en,
    output logic              current_loop_en,
    output logic              pwm_in_range,
    output logic      [W-1:0] pwm_in_period,
    output logic              hs_on,
    output logic              ls_on
);
    logic          pin_d;
    logic [W-1:0]  cnt;
    logic [W-1:0]  high_cnt;
    logic [W-1:0]  period;
    logic [W-1:0]  high_time;
    logic [W-1:0]  win_cnt;
    logic [W-1:0]  edge_cnt;
    logic [W-1:0]  freq;
    logic [7:0]    pwm_pct;
    logic [W-1:0]  sel_level;
    logic [W-1:0]  sel_entry;
    logic [W-1:0]  sel_exit;
    logic [W-1:0]  sel_full;
    logic [7:0]    scaled;
    logic [7:0]    next_duty;
    mris_pkg::mris_leg_t leg;
    mris_pkg::mris_leg_t next_leg;
    wire  logic    rise = speed_pin & ~pin_d;
    wire  logic    win_end = win_cnt == W'(`MRIS_WIN_LONG);
    wire  logic [W-1:0] range_min = W'(`MRIS_RANGE_BASE) << speed_range_sel;
    if (W < 8 || W > 24) begin : g_bad_width
        $error("mris_top width out of range");
    end
    // Input period is measured on the pin only; the phase output rate has no tie to it.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_d     <= 1'b0;
            cnt       <= '0;
            high_cnt  <= '0;
            period    <= '0;
            high_time <= '0;
        end else begin
            pin_d <= speed_pin;
            if (rise) begin
                period    <= cnt;
                high_time <= high_cnt;
                cnt       <= W'(1);
                high_cnt  <= W'(speed_pin);
            end else if (cnt != '1) begin
                cnt      <= cnt + W'(1);
                high_cnt <= high_cnt + W'(speed_pin);
            end
        end
    end
    // Constant-high or constant-low pins saturate to full or zero duty.
    assign pwm_pct = (cnt == '1) ? (pin_d ? `MRIS_DUTY_FULL : `MRIS_DUTY_ZERO)
                   : (period == '0) ? `MRIS_DUTY_ZERO
                   : 8'(({8'h00, high_time} * (W+8)'(`MRIS_DUTY_FULL)) / {8'h00, period});
    // Frequency is the count of rising edges in a fixed window.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            win_cnt  <= '0;
            edge_cnt <= '0;
            freq     <= '0;
        end else begin
            win_cnt  <= win_end ? '0 : win_cnt + W'(1);
            edge_cnt <= win_end ? W'(rise) : edge_cnt + W'(rise);
            if (win_end)
                freq <= edge_cnt;
        end
    end
    // Source multiplexer.
    always_comb begin
        case (source_select)
            `MRIS_SRC_ANALOG: begin
                sel_level = analog_level;
                sel_entry = standby_entry_level;
                sel_exit  = standby_exit_level;
                sel_full  = analog_full_scale_level;
            end
            `MRIS_SRC_PWM: begin
                sel_level = W'(pwm_pct);
                sel_entry = W'(standby_entry_duty);
                sel_exit  = W'(standby_exit_duty);
                sel_full  = W'(`MRIS_DUTY_FULL);
            end
            `MRIS_SRC_HOST: begin
                sel_level = W'(host_speed_cmd);
                sel_entry = W'(standby_entry_duty);
                sel_exit  = W'(standby_exit_duty);
                sel_full  = W'(`MRIS_DUTY_FULL);
            end
            default: begin
                sel_level = freq;
                sel_entry = freq_entry;
                sel_exit  = freq_exit;
                sel_full  = input_max_freq;
            end
        endcase
    end
    mris_scale #(.W(W)) u_scale (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .level    (sel_level),
        .entry_th (sel_entry),
        .exit_th  (sel_exit),
        .full_th  (sel_full),
        .duty     (scaled)
    );
    // A PWM input slower than the selected range counts as no input.
    // Either the last full period or the one still running may prove the input too slow.
    assign next_duty = (source_select == `MRIS_SRC_PWM && cnt != '1
                        && (cnt > range_min || period > range_min)) ? `MRIS_DUTY_ZERO : scaled;
    // Dead-time interlock: a leg turns on only once the opposite gate is sensed off.
    always_comb begin
        case (leg)
            mris_pkg::MRIS_OFF:
                next_leg = (bridge_high_req && !ls_gate_sensed_on) ? mris_pkg::MRIS_HS
                         : (!bridge_high_req && !hs_gate_sensed_on) ? mris_pkg::MRIS_LS
                         : mris_pkg::MRIS_OFF;
            mris_pkg::MRIS_HS:
                next_leg = bridge_high_req ? mris_pkg::MRIS_HS : mris_pkg::MRIS_OFF;
            mris_pkg::MRIS_LS:
                next_leg = bridge_high_req ? mris_pkg::MRIS_OFF : mris_pkg::MRIS_LS;
            default:
                next_leg = mris_pkg::MRIS_OFF;
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            duty_cmd        <= `MRIS_DUTY_ZERO;
            speed_ref       <= `MRIS_DUTY_ZERO;
            current_ref     <= `MRIS_DUTY_ZERO;
            speed_loop_en   <= 1'b1;
            current_loop_en <= 1'b0;
            pwm_in_range    <= 1'b0;
            pwm_in_period   <= '0;
            leg             <= mris_pkg::MRIS_OFF;
            hs_on           <= 1'b0;
            ls_on           <= 1'b0;
        end else begin
            duty_cmd        <= next_duty;
            speed_ref       <= closed_loop_select ? `MRIS_DUTY_ZERO : next_duty;
            current_ref     <= closed_loop_select ? next_duty : `MRIS_DUTY_ZERO;
            speed_loop_en   <= !closed_loop_select;
            current_loop_en <= closed_loop_select;
            pwm_in_range    <= period != '0 && period <= range_min;
            pwm_in_period   <= period;
            leg             <= next_leg;
            hs_on           <= next_leg == mris_pkg::MRIS_HS;
            ls_on           <= next_leg == mris_pkg::MRIS_LS;
        end
    end
endmodule : mris_top

// *** rtl/mris_cfg.svh ***
// Constants for the motor reference input select block.
// Assumes it is included by bare name from rtl files; holds definitions only.
`ifndef MRIS_CFG_SVH
`define MRIS_CFG_SVH
`define MRIS_SRC_ANALOG 2'h0
`define MRIS_SRC_PWM    2'h1
`define MRIS_SRC_HOST   2'h2
`define MRIS_SRC_FREQ   2'h3
`define MRIS_DUTY_FULL  8'hff
`define MRIS_DUTY_ZERO  8'h00
`define MRIS_RANGE_BASE 16'h0010
`define MRIS_WIN_LONG   16'hffff
`define MRIS_OUT_FREQ_RST 16'h0400
`endif

// *** rtl/mris_pkg.sv ***
// Types for the motor reference input select block.
// Assumes the cfg header holds the numeric constants.
package mris_pkg;
    typedef enum logic [2:0] {
        MRIS_OFF  = 3'b001,
        MRIS_HS   = 3'b010,
        MRIS_LS   = 3'b100
    } mris_leg_t;
endpackage : mris_pkg

// *** rtl/mris_scale.sv ***
// Linear scale with standby thresholds and full-scale clamp.
// Assumes thresholds are ordered entry <= exit < full.
`timescale 1ns/1ps
`include "mris_cfg.svh"
module mris_scale #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] level,
    input  wire logic [W-1:0] entry_th,
    input  wire logic [W-1:0] exit_th,
    input  wire logic [W-1:0] full_th,
    output logic      [7:0]   duty
);
    logic          running;
    logic          next_running;
    logic [W+7:0]  num;
    logic [W-1:0]  span;
    logic [7:0]    lin;
    wire  logic    below = level <= entry_th;
    wire  logic    above = level >= exit_th;
    if (W < 2 || W > 24) begin : g_bad_width
        $error("mris_scale width out of range");
    end
    // A divider per sample is costly, but inputs change slowly so area wins over speed here.
    assign span = (full_th > exit_th) ? full_th - exit_th : {{(W-1){1'b0}}, 1'b1};
    assign num  = {(level - exit_th), 8'h00} - {8'h00, level - exit_th};
    assign lin  = 8'((num) / {8'h00, span});
    // Run state holds between thresholds, yet duty is zero whenever level is below exit_th, whatever the run state.
    assign next_running = below ? 1'b0 : (above ? 1'b1 : running);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            running <= 1'b0;
            duty    <= `MRIS_DUTY_ZERO;
        end else begin
            running <= next_running;
            if (!next_running || level < exit_th)
                duty <= `MRIS_DUTY_ZERO;
            else if (level >= full_th)
                duty <= `MRIS_DUTY_FULL;
            else
                duty <= lin;
        end
    end
endmodule : mris_scale

// *** tb/mris_checker.sv ***
// Checker bound onto the reference select top.
// Assumes the top ports as declared; sees nothing inside.
`timescale 1ns/1ps
module mris_checker #(
    parameter int W = 16
) (
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic [1:0]   source_select,
    input wire logic         closed_loop_select,
    input wire logic [W-1:0] analog_level,
    input wire logic [W-1:0] standby_entry_level,
    input wire logic [W-1:0] analog_full_scale_level,
    input wire logic [7:0]   host_speed_cmd,
    input wire logic [7:0]   standby_entry_duty,
    input wire logic         pwm_in_range,
    input wire logic         hs_gate_sensed_on,
    input wire logic         ls_gate_sensed_on,
    input wire logic [7:0]   duty_cmd,
    input wire logic [7:0]   speed_ref,
    input wire logic [7:0]   current_ref,
    input wire logic         speed_loop_en,
    input wire logic         current_loop_en,
    input wire logic         hs_on,
    input wire logic         ls_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_speed_route: assert property ((!closed_loop_select)[*3] |->
        speed_loop_en && !current_loop_en && speed_ref == duty_cmd) else $error("speed route");
    chk_current_route: assert property (closed_loop_select[*3] |->
        current_loop_en && !speed_loop_en && current_ref == duty_cmd) else $error("current route");
    chk_analog_stop: assert property ((source_select == 2'h0 &&
        analog_level <= standby_entry_level)[*4] |-> duty_cmd == 8'h00) else $error("analog stop");
    chk_analog_clamp: assert property ((source_select == 2'h0 &&
        analog_level > analog_full_scale_level)[*4] |-> duty_cmd == 8'hff) else $error("clamp");
    chk_host_stop: assert property ((source_select == 2'h2 &&
        host_speed_cmd <= standby_entry_duty)[*4] |-> duty_cmd == 8'h00) else $error("host stop");
    chk_pwm_refused: assert property ((source_select == 2'h1 && !pwm_in_range)[*4]
        |-> duty_cmd == 8'h00) else $error("refused period");
    chk_high_dead: assert property ($rose(hs_on) |-> !$past(ls_gate_sensed_on))
        else $error("high leg early");
    chk_low_dead: assert property ($rose(ls_on) |-> !$past(hs_gate_sensed_on))
        else $error("low leg early");
endmodule : mris_checker
bind mris_top mris_checker #(.W(W)) chk_u (.clk(clk), .sys_rst(sys_rst),
    .source_select(source_select), .closed_loop_select(closed_loop_select),
    .analog_level(analog_level), .standby_entry_level(standby_entry_level),
    .analog_full_scale_level(analog_full_scale_level), .host_speed_cmd(host_speed_cmd),
    .standby_entry_duty(standby_entry_duty), .pwm_in_range(pwm_in_range),
    .hs_gate_sensed_on(hs_gate_sensed_on), .ls_gate_sensed_on(ls_gate_sensed_on),
    .duty_cmd(duty_cmd), .speed_ref(speed_ref), .current_ref(current_ref),
    .speed_loop_en(speed_loop_en), .current_loop_en(current_loop_en),
    .hs_on(hs_on), .ls_on(ls_on));

// *** tb/mris_pwm_src.sv ***
// Far-side PWM source on the speed pin.
// Assumes hi is nonzero; lo of zero gives a pin stuck high.
`timescale 1ns/1ps
module mris_pwm_src (
    input  wire logic       clk,
    input  wire logic       en,
    input  wire logic [7:0] hi,
    input  wire logic [7:0] lo,
    output logic            pin = 1'b0
);
    logic [8:0] cnt = 9'h000;
    // The pin rests low when idle, as the pull-down would hold it.
    // Low phases stay far shorter than any sleep entry delay a host would program.
    always_ff @(posedge clk) begin
        cnt <= (!en || cnt + 9'h001 >= hi + lo) ? 9'h000 : cnt + 9'h001;
        pin <= en && (cnt < {1'b0, hi});
    end
endmodule : mris_pwm_src

// *** tb/motor_reference_input_select_tb.sv ***
// Self-checking bench for the reference select block.
// Assumes the checker is bound and the PWM model drives the pin.
`timescale 1ns/1ps
module motor_reference_input_select_tb;
    logic [7:0]  duty, sref, cref, e, c, cmd = 8'h00, phi = 8'h00, plo = 8'h00;
    logic [15:0] lvl = 16'h0000, lfsr = 16'h1e54, v, per;
    logic [1:0]  src = 2'h0, rsel = 2'h0;
    logic        clk = 1'b0, sys_rst = 1'b1, cls = 1'b0, req = 1'b0, pen = 1'b0;
    logic        hs_s = 1'b0, ls_s = 1'b0, pin, sen, cen, rng, hs, ls, look = 1'b0;
    logic [7:0]  exq[$];
    logic [7:0]  ent = 8'h20, ext = 8'h40;
    logic [15:0] afs = 16'h0a00;
    int          n_mismatch = 0, checks = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    // Gate sense trails the drive by a cycle, like a real gate discharging.
    always @(posedge clk) begin
        hs_s <= hs;
        ls_s <= ls;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    mris_pwm_src pwm_u (.clk(clk), .en(pen), .hi(phi), .lo(plo), .pin(pin));
    mris_top dut_u (.clk(clk), .sys_rst(sys_rst), .source_select(src),
        .closed_loop_select(cls), .analog_level(lvl), .speed_pin(pin),
        .host_speed_cmd(cmd), .speed_range_sel(rsel), .standby_entry_level(16'h0100),
        .standby_exit_level(16'h0200), .analog_full_scale_level(afs),
        .standby_entry_duty(ent), .standby_exit_duty(ext), .freq_entry(16'h0010),
        .freq_exit(16'h0020), .input_max_freq(16'h0100), .bridge_high_req(req),
        .hs_gate_sensed_on(hs_s), .ls_gate_sensed_on(ls_s), .duty_cmd(duty),
        .speed_ref(sref), .current_ref(cref), .speed_loop_en(sen), .current_loop_en(cen),
        .pwm_in_range(rng), .pwm_in_period(per), .hs_on(hs), .ls_on(ls));
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : step
    function automatic logic [7:0] lin_exp(input logic [7:0] p);
        return (p < ext) ? 8'h00 : 8'((32'(p) - 32'(ext)) * 32'hff / (32'hff - 32'(ext)));
    endfunction : lin_exp
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic put(input logic [1:0] s, input logic [15:0] l, input logic [7:0] k,
                       input int w, input logic [7:0] x);
        src <= s;
        lvl <= l;
        cmd <= k;
        repeat (w) @(posedge clk);
        exq.push_back(x);
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : put
    always @(negedge clk) begin
        if (look === 1'b1) begin
            e = exq.pop_front();
            chk(duty, e);
            chk(cls ? cref : sref, e);
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        put(2'h0, 16'h0080, 8'h00, 6, 8'h00);
        put(2'h0, 16'h0180, 8'h00, 6, 8'h00);
        put(2'h0, 16'h0c00, 8'h00, 6, 8'hff);
        repeat (6) begin
            lfsr = step(lfsr);
            v = 16'h0200 + {5'h00, lfsr[10:0]};
            put(2'h0, v, 8'h00, 6, 8'((32'(v) - 32'h200) * 32'hff / 32'h800));
        end
        afs <= 16'h0600;
        put(2'h0, 16'h0700, 8'h00, 6, 8'hff);
        afs <= 16'h0a00;
        put(2'h0, 16'h0080, 8'h00, 6, 8'h00);
        put(2'h2, 16'h0000, 8'h10, 6, 8'h00);
        put(2'h2, 16'h0000, 8'hff, 6, 8'hff);
        repeat (4) begin
            lfsr = step(lfsr);
            c = 8'h40 + {1'b0, lfsr[6:0]};
            put(2'h2, 16'h0000, c, 6, lin_exp(c));
        end
        ent <= 8'h50;
        ext <= 8'h80;
        put(2'h2, 16'h0000, 8'h48, 6, 8'h00);
        put(2'h2, 16'h0000, 8'hc0, 6, lin_exp(8'hc0));
        ent <= 8'h20;
        ext <= 8'h40;
        put(2'h3, 16'h0000, 8'h00, 6, 8'h00);
        cls <= 1'b1;
        put(2'h2, 16'h0000, 8'hff, 6, 8'hff);
        chk({7'h00, cen}, 8'h01);
        cls <= 1'b0;
        put(2'h2, 16'h0000, 8'hff, 6, 8'hff);
        chk({7'h00, sen}, 8'h01);
        put(2'h1, 16'h0000, 8'h00, 300, 8'h00);
        pen <= 1'b1;
        repeat (2) begin
            lfsr = step(lfsr);
            c = 8'h08 + {5'h00, lfsr[2:0]};
            phi <= c;
            plo <= 8'h10 - c;
            put(2'h1, 16'h0000, 8'h00, 300, lin_exp(8'(32'(c) * 32'hff / 32'h10)));
        end
        phi <= 8'h14;
        plo <= 8'h14;
        put(2'h1, 16'h0000, 8'h00, 300, 8'h00);
        chk({7'h00, rng}, 8'h00);
        rsel <= 2'h2;
        put(2'h1, 16'h0000, 8'h00, 300, lin_exp(8'h7f));
        chk({7'h00, rng}, 8'h01);
        chk(per[7:0], 8'h28);
        req <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({6'h00, hs, ls}, 8'h02);
        @(posedge clk);
        req <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({6'h00, hs, ls}, 8'h01);
        conclude();
    end
endmodule : motor_reference_input_select_tb
